// *** src/opmpc_pkg.sv ***
`default_nettype none
package opmpc_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_P2_DDR = 8'h01;
	localparam logic [7:0] IDX_P2_DATA = 8'h03;
	localparam logic [7:0] IDX_P3_DDR = 8'h04;
	localparam logic [7:0] IDX_P4_DDR = 8'h05;
	localparam logic [7:0] IDX_P3_DATA = 8'h06;
	localparam logic [7:0] IDX_P4_DATA = 8'h07;
	localparam logic [7:0] IDX_EXT_ADDR = 8'h08;
	localparam logic [7:0] IDX_EXT_DATA = 8'h09;
	localparam logic [7:0] IDX_EXT_CTRL = 8'h0A;
	// Field positions.
	localparam int P2_MODE_LSB = 5;
	localparam int P2_LEAVE_TEST_BIT = 5;
	localparam int CTRL_START_RD_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_RAM_HIT_BIT = 2;
	// Mode numbers.
	localparam logic [2:0] MODE_MUX_TEST = 3'h0;
	localparam logic [2:0] MODE_SC_TEST = 3'h4;
	localparam logic [2:0] MODE_NMUX = 3'h5;
	localparam logic [2:0] MODE_MUX_PARTIAL = 3'h6;
	localparam logic [2:0] MODE_SC = 3'h7;
	// Address windows and vectors.
	localparam logic [15:0] NMUX_WIN_LO = 16'h0100;
	localparam logic [15:0] NMUX_WIN_HI = 16'h01FF;
	localparam logic [7:0] RAM_LOW_BYTE_LO = 8'h80;
	localparam logic [15:0] VEC_SC_TEST = 16'hFFFE;
	localparam logic [15:0] VEC_MUX_TEST = 16'hBFFE;
	localparam logic [15:0] VEC_DEFAULT = 16'hFFFE;
	// Reset values.
	localparam logic [7:0] RST_DDR = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [15:0] RST_EXT_ADDR = 16'h0000;
	// Timing: each quarter of the bus phase clock.
	localparam int CLK_PERIOD_NS = 10;
	localparam int E_QUARTER_NS = 50;
	localparam int E_QUARTER_CYC = (E_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA} opmpc_state_t;
endpackage
`default_nettype wire

// *** src/opmpc_top.sv ***
`default_nettype none
module opmpc_top
	import opmpc_pkg::*;
#(
	parameter int QUARTER_CYC = E_QUARTER_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Mode straps and port 2
	input wire logic [2:0] mode_select_pins,
	input wire logic [4:0] p2_in,
	output logic [4:0] p2_out,
	output logic [4:0] p2_oe_n,
	// Port 3
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe_n,
	// Port 4
	input wire logic [7:0] p4_in,
	output logic [7:0] p4_out,
	output logic [7:0] p4_oe_n,
	// Strobe-control pins
	input wire logic strobe_line_one_in,
	output logic strobe_line_one_out,
	output logic strobe_line_one_oe_n,
	output logic strobe_line_two_out,
	output logic strobe_line_two_oe_n,
	// Bus phase clock and status
	output logic e_clock,
	output logic [15:0] reset_vector_addr,
	output logic rom_enable
);
	// The quarter counter is eight bits wide, so longer quarters cannot be timed.
	if (QUARTER_CYC < 1 || QUARTER_CYC > 255) begin : g_bad_quarter
		$error("QUARTER_CYC out of range");
	end

	////////////////////////////////////////////////////////////////////////
	logic [2:0] mode_latch_bits_reg;
	logic mode_taken_reg;
	logic [4:0] p2_ddr_reg, p2_data_reg;
	logic [7:0] p3_ddr_reg, p4_ddr_reg, p3_data_reg, p4_data_reg;
	logic [15:0] ext_addr_reg;
	logic [7:0] ext_wdata_reg, ext_rdata_reg;
	logic ext_rd_reg, refused_reg, start_pend_reg;
	logic [7:0] div_reg;
	logic [1:0] phase_reg;
	opmpc_state_t state_reg, state_next;
	logic os3_reg;
	logic wr_pend_reg;
	logic [7:0] wr_idx_reg;

	// Mode decode.
	wire is_single = (mode_latch_bits_reg == MODE_SC_TEST) ||
		(mode_latch_bits_reg == MODE_SC);
	wire is_nmux = (mode_latch_bits_reg == MODE_NMUX);
	wire is_mux = !is_single && !is_nmux;
	wire is_test4 = (mode_latch_bits_reg == MODE_SC_TEST);
	wire in_window = (ext_addr_reg >= NMUX_WIN_LO) && (ext_addr_reg <= NMUX_WIN_HI);
	wire ram_hit = is_test4 && (ext_addr_reg[7:0] >= RAM_LOW_BYTE_LO);

	// Bus decode.
	// Only the low byte of write data matters, except for the 16-bit address register.
	wire addr_take = hsel && htrans[1] && hready;
	wire [7:0] a_idx = haddr[9:2];
	wire w_en = wr_pend_reg;
	wire [7:0] wd = hwdata[7:0];
	wire w_p2d = w_en && (wr_idx_reg == IDX_P2_DATA);
	wire w_p3d = w_en && (wr_idx_reg == IDX_P3_DATA);
	wire w_ext_data = w_en && (wr_idx_reg == IDX_EXT_DATA);
	wire w_ctrl_rd = w_en && (wr_idx_reg == IDX_EXT_CTRL) && hwdata[CTRL_START_RD_BIT];
	wire start_req = w_ext_data || w_ctrl_rd;
	wire start_ok = is_mux || (is_nmux && in_window);
	wire tick = (div_reg == 8'(QUARTER_CYC - 1));
	wire cycle_go = start_pend_reg && tick && (phase_reg == 2'h3);
	wire [4:0] p2_level = (p2_ddr_reg & p2_data_reg) | (~p2_ddr_reg & p2_in);
	wire busy = start_pend_reg || (state_reg != ST_IDLE);

	// Register read selection.
	// A read right behind a write to the same register returns the old value.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (a_idx)
			IDX_P2_DDR: rd_mux = {27'h0, p2_ddr_reg};
			IDX_P2_DATA: rd_mux = {24'h0, mode_latch_bits_reg, p2_level};
			IDX_P3_DDR: rd_mux = {24'h0, p3_ddr_reg};
			IDX_P4_DDR: rd_mux = {24'h0, p4_ddr_reg};
			IDX_P3_DATA: rd_mux = {24'h0, p3_in};
			IDX_P4_DATA: rd_mux = {24'h0, p4_in};
			IDX_EXT_ADDR: rd_mux = {16'h0, ext_addr_reg};
			IDX_EXT_DATA: rd_mux = {24'h0, ext_rdata_reg};
			IDX_EXT_CTRL: rd_mux = {29'h0, ram_hit, refused_reg, busy};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite: zero wait states; write data is taken in the data phase.
	// Every transfer answers OKAY; unmapped indices read zero and ignore writes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= addr_take && hwrite;
			wr_idx_reg <= a_idx;
			hrdata <= (addr_take && !hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// The straps cannot feed an asynchronous reset, so the first clock after release takes them.
	// Leaving the test mode is one-way: only a new reset brings mode 4 back.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_taken_reg <= 1'b0;
			mode_latch_bits_reg <= MODE_MUX_TEST;
		end else if (!mode_taken_reg) begin
			mode_taken_reg <= 1'b1;
			mode_latch_bits_reg <= mode_select_pins;
		end else if (w_p2d && is_test4 && wd[P2_LEAVE_TEST_BIT]) begin
			mode_latch_bits_reg <= MODE_NMUX;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p2_ddr_reg <= RST_DDR[4:0];
			p2_data_reg <= RST_DATA[4:0];
			p3_ddr_reg <= RST_DDR;
			p4_ddr_reg <= RST_DDR;
			p3_data_reg <= RST_DATA;
			p4_data_reg <= RST_DATA;
			ext_addr_reg <= RST_EXT_ADDR;
			ext_wdata_reg <= RST_DATA;
		end else if (w_en) begin
			case (wr_idx_reg)
				IDX_P2_DDR: p2_ddr_reg <= wd[4:0];
				IDX_P2_DATA: p2_data_reg <= wd[4:0];
				IDX_P3_DDR: p3_ddr_reg <= wd;
				IDX_P4_DDR: p4_ddr_reg <= wd;
				IDX_P3_DATA: p3_data_reg <= wd;
				IDX_P4_DATA: p4_data_reg <= wd;
				IDX_EXT_ADDR: ext_addr_reg <= hwdata[15:0];
				IDX_EXT_DATA: ext_wdata_reg <= wd;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The bus phase clock runs free; a cycle starts at the next quarter 0.
	// A longer quarter only stretches the cycle; the order of its quarters stays the same.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 8'h00;
			phase_reg <= 2'h0;
		end else begin
			div_reg <= tick ? 8'h00 : div_reg + 8'h01;
			if (tick) begin
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = cycle_go ? ST_ADDR : ST_IDLE;
			ST_ADDR: state_next = tick ? ST_GAP : ST_ADDR;
			ST_GAP: state_next = tick ? ST_DATA : ST_GAP;
			ST_DATA: state_next = (tick && phase_reg == 2'h3) ? ST_IDLE : ST_DATA;
			default: state_next = ST_IDLE;
		endcase
	end

	// A start while busy is dropped; a start in a mode or window without a bus is refused.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			start_pend_reg <= 1'b0;
			ext_rd_reg <= 1'b1;
			refused_reg <= 1'b0;
			ext_rdata_reg <= RST_DATA;
			os3_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (start_req && !busy) begin
				start_pend_reg <= start_ok;
				refused_reg <= !start_ok;
				ext_rd_reg <= w_ctrl_rd;
			end else if (cycle_go) begin
				start_pend_reg <= 1'b0;
			end
			if (state_reg == ST_DATA && tick && phase_reg == 2'h3 && ext_rd_reg) begin
				ext_rdata_reg <= p3_in;
			end
			if (w_p3d && is_single) begin
				os3_reg <= 1'b1;
			end else if (tick) begin
				os3_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive selection by mode.
	// Every pin comes from a flip-flop, so the pins follow the cycle state one clock late.
	wire drive_wr = (state_reg == ST_DATA) && !ext_rd_reg;
	wire bus_on = (state_reg != ST_IDLE);
	wire [7:0] p3_out_nx = is_single ? p3_data_reg :
		(is_mux && state_reg == ST_ADDR) ? ext_addr_reg[7:0] : ext_wdata_reg;
	wire [7:0] p3_oe_n_nx = is_single ? ~p3_ddr_reg :
		(drive_wr || (is_mux && state_reg == ST_ADDR)) ? 8'h00 : 8'hFF;
	wire [7:0] p4_out_nx = is_single ? p4_data_reg :
		is_nmux ? ext_addr_reg[7:0] : ext_addr_reg[15:8];
	// In the partial-decode mode an address line drives only once software enables it.
	wire [7:0] p4_oe_n_nx = is_single ? ~p4_ddr_reg :
		is_nmux ? ~p4_ddr_reg :
		(mode_latch_bits_reg == MODE_MUX_PARTIAL) ? ~p4_ddr_reg : 8'h00;
	wire sc1_out_nx = is_nmux ? (bus_on && in_window) :
		is_mux ? (state_reg == ST_ADDR) : 1'b0;
	wire sc1_oe_n_nx = is_single;
	wire sc2_out_nx = is_single ? os3_reg : (!bus_on || ext_rd_reg);
	// The vector is only reported here; fetching it belongs to the processor core.
	wire [15:0] vec_nx = is_test4 ? VEC_SC_TEST :
		(mode_latch_bits_reg == MODE_MUX_TEST) ? VEC_MUX_TEST : VEC_DEFAULT;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p2_out <= 5'h00;
			p2_oe_n <= 5'h1F;
			p3_out <= 8'h00;
			p3_oe_n <= 8'hFF;
			p4_out <= 8'h00;
			p4_oe_n <= 8'hFF;
			strobe_line_one_out <= 1'b0;
			strobe_line_one_oe_n <= 1'b1;
			strobe_line_two_out <= 1'b1;
			strobe_line_two_oe_n <= 1'b1;
			e_clock <= 1'b0;
			reset_vector_addr <= VEC_DEFAULT;
			rom_enable <= 1'b1;
		end else begin
			p2_out <= p2_data_reg;
			p2_oe_n <= ~p2_ddr_reg;
			p3_out <= p3_out_nx;
			p3_oe_n <= p3_oe_n_nx;
			p4_out <= p4_out_nx;
			p4_oe_n <= p4_oe_n_nx;
			strobe_line_one_out <= sc1_out_nx;
			strobe_line_one_oe_n <= sc1_oe_n_nx;
			strobe_line_two_out <= sc2_out_nx;
			strobe_line_two_oe_n <= !mode_taken_reg;
			e_clock <= phase_reg[1];
			reset_vector_addr <= vec_nx;
			rom_enable <= !is_test4;
		end
	end

	// The single-chip input strobe is accepted on this pin but not yet latched by this block.
	wire unused_ok = &{1'b0, strobe_line_one_in, hsize, haddr[31:10], haddr[1:0], hwdata[31:16]};
endmodule
`default_nettype wire

// *** test/opmpc_checker.sv ***
`default_nettype none
module opmpc_checker
	import opmpc_pkg::*;
#(
	parameter int QUARTER_CYC = 1
) (
	// Bus side
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Pin side
	input wire logic [2:0] mode_select_pins,
	input wire logic [7:0] p3_oe_n,
	input wire logic [7:0] p4_oe_n,
	input wire logic strobe_line_one_out,
	input wire logic strobe_line_one_oe_n,
	input wire logic strobe_line_two_oe_n,
	input wire logic e_clock,
	input wire logic [15:0] reset_vector_addr,
	input wire logic rom_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] hi_cnt;
	logic [1:0] up_cnt;
	logic up;
	////////////////////////////////////////
	// Straps only change while reset is held, so they stand for the mode.
	// The pins show the latched mode from the second edge after release on.
	assign up = up_cnt[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_cnt <= 8'h00;
			up_cnt <= 2'h0;
		end else begin
			hi_cnt <= e_clock ? hi_cnt + 8'h01 : 8'h00;
			if (!up_cnt[1]) begin
				up_cnt <= up_cnt + 2'h1;
			end
		end
	end
	////////////////////////////////////////
	property p_rom; up && mode_select_pins != 3'h4 |-> rom_enable; endproperty
	a_rom: assert property (p_rom) else $error("rom disabled outside mode 4");
	property p_vec; up |-> reset_vector_addr == (mode_select_pins == 3'h0 ? 16'hBFFE : 16'hFFFE);
	endproperty
	a_vec: assert property (p_vec) else $error("reset vector wrong");
	property p_sc; up && mode_select_pins == 3'h7 |-> strobe_line_one_oe_n; endproperty
	a_sc: assert property (p_sc) else $error("input strobe driven");
	property p_p4; up && !mode_select_pins[2] |-> p4_oe_n == 8'h00; endproperty
	a_p4: assert property (p_p4) else $error("upper address not driven");
	property p_gap; !mode_select_pins[2] && $fell(strobe_line_one_out) |-> &p3_oe_n; endproperty
	a_gap: assert property (p_gap) else $error("port 3 driven after strobe");
	property p_ehi; $fell(e_clock) |-> hi_cnt == 8'(2 * QUARTER_CYC); endproperty
	a_ehi: assert property (p_ehi) else $error("phase clock high time wrong");
	property p_strb; up && mode_select_pins != 3'h4 && mode_select_pins != 3'h7
		|-> !strobe_line_one_oe_n && !strobe_line_two_oe_n; endproperty
	a_strb: assert property (p_strb) else $error("bus strobes not driven");
	property p_rdz; !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside data phase");
endmodule
`default_nettype wire

// *** test/opmpc_ext_mem.sv ***
`default_nettype none
module opmpc_ext_mem (
	// Clock and mode
	input wire logic hclk,
	input wire logic nmux,
	// From the block
	input wire logic e_clock,
	input wire logic as_strobe,
	input wire logic rd_dir,
	input wire logic [7:0] p3_out,
	input wire logic [7:0] p3_oe_n,
	input wire logic [7:0] p4_out,
	// To the block
	output logic [7:0] p3_in,
	output logic [7:0] p4_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] lo_addr;
	wire logic [7:0] idx;
	assign idx = nmux ? p4_out : lo_addr;
	assign p4_in = 8'hFF;
	// A released bus shows the inverse of the last value, so stale data cannot match.
	assign p3_in = (e_clock && rd_dir && &p3_oe_n) ? mem[idx] : ~p3_out;
	always_ff @(posedge hclk) begin
		if (as_strobe) begin
			lo_addr <= p3_out;
		end
		if (e_clock && !rd_dir && !p3_oe_n[0]) begin
			mem[idx] <= p3_out;
		end
	end
endmodule
`default_nettype wire

// *** test/test_operating_mode_port_config.sv ***
`default_nettype none
module test_operating_mode_port_config
	import opmpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, q;
	logic [2:0] mode_select_pins;
	logic [4:0] p2_in;
	logic [7:0] rnd;
	wire logic hready, hreadyout, hresp, e_clock, rom_enable;
	wire logic strobe_line_one_out, strobe_line_one_oe_n, strobe_line_two_out, strobe_line_two_oe_n;
	wire logic [31:0] hrdata;
	wire logic [4:0] p2_out, p2_oe_n;
	wire logic [7:0] p3_in, p3_out, p3_oe_n, p4_in, p4_out, p4_oe_n;
	wire logic [15:0] reset_vector_addr;
	int n_errors, check_count;
	assign hready = hreadyout;
	opmpc_top #(.QUARTER_CYC(1)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .mode_select_pins,
		.p2_in, .p2_out, .p2_oe_n, .p3_in, .p3_out, .p3_oe_n, .p4_in, .p4_out, .p4_oe_n,
		.strobe_line_one_in(1'b0), .strobe_line_one_out, .strobe_line_one_oe_n,
		.strobe_line_two_out, .strobe_line_two_oe_n, .e_clock, .reset_vector_addr, .rom_enable);
	opmpc_ext_mem far_side (.hclk, .nmux(mode_select_pins == 3'h5), .e_clock,
		.as_strobe(strobe_line_one_out), .rd_dir(strobe_line_two_out), .p3_out, .p3_oe_n,
		.p4_out, .p3_in, .p4_in);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [15:0] exp_vec(input logic [2:0] m);
		return (m == MODE_MUX_TEST) ? 16'hBFFE : 16'hFFFE;
	endfunction
	function automatic logic [4:0] exp_p2(input logic [4:0] dir, input logic [4:0] dat,
		input logic [4:0] pin);
		return (dir & dat) | (~dir & pin);
	endfunction
	function automatic logic [7:0] exp_p4(input logic [2:0] m, input logic [7:0] d);
		return m[2] ? ~d : 8'h00;
	endfunction
	task automatic results;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (hready !== 1'b1) begin
			n_errors++;
			results();
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	// Busy is polled, never timed, so a slower bus cycle still passes.
	task automatic poll;
		int n;
		n = 0;
		do begin
			xf(1'b0, IDX_EXT_CTRL, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 200);
		if (q[STAT_BUSY_BIT] !== 1'b0) begin
			n_errors++;
			results();
		end
	endtask
	task automatic ext(input logic [15:0] a, input logic [7:0] d, input logic rf);
		xf(1'b1, IDX_EXT_ADDR, {16'h0, a});
		xf(1'b1, IDX_EXT_DATA, {24'h0, d});
		poll();
		chk("refused", 32'(rf), 32'(q[STAT_REFUSED_BIT]));
		if (!rf) begin
			xf(1'b1, IDX_EXT_CTRL, 32'h1);
			poll();
			xf(1'b0, IDX_EXT_DATA, 32'h0);
			chk("ext data", 32'(d), 32'(q[7:0]));
		end
	endtask
	////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		mode_select_pins = 3'h0;
		p2_in = 5'h00;
		rnd = 8'h5F;
		n_errors = 0;
		check_count = 0;
		// Modes 0, 1, 2 and 3 run before the test mode; each mode starts from its own reset.
		for (int m = 0; m < 8; m++) begin
			@(posedge hclk);
			hresetn <= 1'b0;
			mode_select_pins <= 3'(m);
			rnd = lfsr(rnd);
			p2_in <= rnd[4:0];
			repeat (20) @(posedge hclk);
			hresetn <= 1'b1;
			repeat (3) @(posedge hclk);
			xf(1'b0, IDX_P2_DATA, 32'h0);
			chk("p2 mode", 32'(m), 32'(q[7:5]));
			chk("p2 pins", 32'(p2_in), 32'(q[4:0]));
			chk("rom", 32'(m != 4), 32'(rom_enable));
			chk("vector", 32'(exp_vec(3'(m))), 32'(reset_vector_addr));
			chk("p4 dir", 32'(exp_p4(3'(m), 8'h00)), 32'(p4_oe_n));
			rnd = lfsr(rnd);
			xf(1'b1, IDX_P4_DDR, 32'(rnd));
			repeat (2) @(posedge hclk);
			chk("p4 dir", 32'(exp_p4(3'(m), rnd)), 32'(p4_oe_n));
			// Bit 5 of the data write stays clear so the test mode is not left here.
			xf(1'b1, IDX_P2_DDR, 32'(rnd[7:3]));
			xf(1'b1, IDX_P2_DATA, 32'(rnd[4:0]));
			xf(1'b0, IDX_P2_DATA, 32'h0);
			chk("p2 level", 32'(exp_p2(rnd[7:3], rnd[4:0], p2_in)), 32'(q[4:0]));
			chk("p2 oe", {27'h0, ~rnd[7:3]}, 32'(p2_oe_n));
			chk("p2 out", 32'(rnd[4:0]), 32'(p2_out));
			if (m == 5) begin
				ext(16'h0200, rnd, 1'b1);
			end
			ext(m == 5 ? {8'h01, rnd} : {rnd, ~rnd}, ~rnd, m == 4 || m == 7);
			if (m == 4) begin
				xf(1'b1, IDX_P2_DATA, 32'h20);
				xf(1'b1, IDX_P2_DATA, 32'h0);
				xf(1'b0, IDX_P2_DATA, 32'h0);
				chk("p2 mode", 32'h5, 32'(q[7:5]));
			end
		end
		xf(1'b1, 8'h02, 32'hFF);
		xf(1'b0, 8'h02, 32'h0);
		chk("unmapped", 32'h0, q);
		results();
	end
endmodule
bind opmpc_top opmpc_checker #(.QUARTER_CYC(QUARTER_CYC)) chk_i (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hrdata, .mode_select_pins, .p3_oe_n, .p4_oe_n,
	.strobe_line_one_out, .strobe_line_one_oe_n, .strobe_line_two_oe_n, .e_clock,
	.reset_vector_addr, .rom_enable);
`default_nettype wire
